//--- tb/fpec_flash_model.sv
// flash array stand-in: answers each read pulse one cycle later
// assumes reads arrive one per cycle, in back-to-back runs or single pulses, with a settled address
`timescale 1ns/1ps
module fpec_flash_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rd,
    input  wire logic [15:0] i_addr,
    output logic      [7:0]  o_rdata
);
    // idle cycles show the inverse, so a stale byte is never summed by luck
    always_ff @(posedge i_clk_sys)
    begin
        o_rdata <= i_rd ? (i_addr[7:0] ^ 8'h5a) : ~o_rdata;
    end
endmodule : fpec_flash_model

//--- tb/tb_fpec_ctrl.sv
// self-checking bench for the flash program/erase controller
// assumes the array stand-in model and a 200 MHz system clock
`timescale 1ns/1ps
module tb_fpec_ctrl;
    import fpec_pkg::*;
    logic        i_clk_sys  = 1'b0;
    logic        i_srst     = 1'b1;
    logic        i_crys_clk = 1'b0;
    fpec_bus_s   i_sfr      = '0;
    fpec_bus_s   i_xd       = '0;
    logic [7:0]  o_sfr_rdata, o_xd_rdata, i_fl_rdata, o_fl_wdata, v;
    logic [15:0] o_fl_addr, wdat;
    logic        o_fl_wr, o_fl_rd, o_fl_prog, o_fl_erase, o_fl_bulk, o_fl_otp, o_cpu_halt;
    int          err_count  = 0;
    int          num_checks = 0;
    int          rises, wrs, brises;
    always #2.5 i_clk_sys = ~i_clk_sys;
    // crystal slower than the system clock so the synchroniser sees every rise
    always #6.1 i_crys_clk = ~i_crys_clk;
    always @(posedge i_crys_clk) if (o_fl_prog | o_fl_erase) rises++;
    always @(posedge i_crys_clk) if (o_fl_bulk === 1'b1) brises++;
    // each programmed byte folded with its address, last two kept
    always @(posedge i_clk_sys)
    begin
        if (o_fl_wr === 1'b1)
        begin
            wrs++;
            wdat = {wdat[7:0], o_fl_wdata ^ o_fl_addr[7:0] ^ o_fl_addr[15:8]};
        end
    end
    fpec_ctrl DUT (.i_clk_sys, .i_srst, .i_sfr, .o_sfr_rdata, .i_xd, .o_xd_rdata, .i_crys_clk,
        .i_fl_rdata, .o_fl_addr, .o_fl_wdata, .o_fl_wr, .o_fl_rd, .o_fl_prog, .o_fl_erase,
        .o_fl_bulk, .o_fl_otp, .o_cpu_halt);
    fpec_flash_model MODEL (.i_clk_sys, .i_rd(o_fl_rd), .i_addr(o_fl_addr), .o_rdata(i_fl_rdata));
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // one bus cycle; read data lands at the edge that takes the strobe
    task automatic acc(input logic x, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        if (x)
            i_xd <= '{w, !w, a, d};
        else
            i_sfr <= '{w, !w, a, d};
        @(posedge i_clk_sys);
        i_xd  <= '0;
        i_sfr <= '0;
        #1 v = x ? o_xd_rdata : o_sfr_rdata;
    endtask : acc
    task automatic sw(input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, {8'h00, a}, d);
    endtask : sw
    task automatic xw(input logic [15:0] a, input logic [7:0] d);
        acc(1'b1, 1'b1, a, d);
    endtask : xw
    task automatic src(input logic [7:0] a, input logic [7:0] e, input string m);
        acc(1'b0, 1'b0, {8'h00, a}, 8'h00);
        chk(v, e, m);
    endtask : src
    task automatic xrc(input logic [15:0] a, input logic [7:0] e, input string m);
        acc(1'b1, 1'b0, a, 8'h00);
        chk(v, e, m);
    endtask : xrc
    // full host sequence; tgt is the timer target, 0 when the start must be refused
    task automatic op(input logic [7:0] cmd, input logic [7:0] mode, input logic [7:0] tm,
                      input logic [15:0] pg, input int tgt);
        logic [23:0] sum;
        int          n;
        rises = 0;
        wrs   = 0;
        brises = 0;
        sw(SFR_TIME, tm);
        sw(SFR_CMD, CMD_PBRST);
        src(SFR_CMD, 8'h01, "buffer reset bit");
        xw(XD_PBUF, 8'h3c);
        xw(XD_PBUF + 16'h0001, 8'hc3);
        sw(SFR_ADDR_H, 8'h00);
        sw(SFR_ADDR_M, pg[15:8]);
        sw(SFR_ADDR_L, pg[7:0]);
        sw(SFR_MODE, mode);
        sw(SFR_CMD, cmd);
        src(SFR_STAT, (tgt == 0) ? 8'h88 : ((cmd == CMD_PROG) ? 8'h04 : 8'h02),
            "status after start");
        if (tgt == 0)
            chk(v & 8'h86, 8'h80, "protected start");
        else
        begin
            chk(v & 8'h8e, (cmd == CMD_PROG) ? 8'h04 : 8'h02, "busy status");
            chk({7'h00, o_cpu_halt}, 8'h01, "cpu halt");
            for (n = 0; n < 4000 && v[7] !== 1'b1; n++)
                acc(1'b0, 1'b0, {8'h00, SFR_STAT}, 8'h00);
            chk(v & 8'h8f, 8'h88, "done status");
        end
        chk(8'(rises >= tgt * 64 - 4 && rises <= tgt * 64 + 4), 8'h01, "timed length");
        chk(8'(wrs), (cmd == CMD_PROG && tgt != 0) ? 8'h02 : 8'h00, "array writes");
        chk(8'(brises == ((mode == 8'ha1) ? rises : 0)), 8'h01, "bulk level");
        if (cmd == CMD_PROG && tgt != 0)
        begin
            chk(wdat[15:8], 8'h3c ^ pg[7:0] ^ pg[15:8], "first array byte");
            chk(wdat[7:0], 8'hc3 ^ (pg[7:0] | 8'h01) ^ pg[15:8], "second byte");
        end
        if (mode == 8'h02)
        begin
            sum = '0;
            for (n = 0; n < 64; n++)
                sum += 24'((pg[7:0] + 8'(n)) ^ 8'h5a);
            xrc(XD_SUM_H, sum[23:16], "checksum high");
            xrc(XD_SUM_M, sum[15:8], "checksum middle");
            xrc(XD_SUM_L, sum[7:0], "checksum low");
        end
    endtask : op
    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        src(SFR_STAT, 8'h80, "status reset");
        src(SFR_CMD, 8'h01, "command reset");
        src(SFR_TIME, 8'h00, "time reset");
        xrc(XD_LB_H, 8'h00, "lock base reset");
        xrc(XD_PCTRL, 8'h00, "protection reset");
        xw(XD_SUM_L, 8'hff);
        xrc(XD_SUM_L, 8'h00, "checksum read-only");
        xrc(16'h2f00, 8'h00, "unmapped read");
        sw(SFR_CMD, CMD_PROG);
        src(SFR_STAT, 8'h80, "start outside session");
        xw(XD_SEQ_A, SEQ_1);
        xw(XD_SEQ_B, SEQ_2);
        xw(XD_SEQ_A, SEQ_3);
        op(CMD_PROG, 8'h02, 8'h02, 16'h1000, 5);
        xw(XD_LB_H, 8'h10);
        xw(XD_LT_H, 8'h10);
        xw(XD_PCTRL, 8'h01);
        op(CMD_ERASE, 8'h00, 8'h00, 16'h1000, 0);
        xw(XD_UB_H, 8'h10);
        xw(XD_UT_H, 8'h10);
        xw(XD_PCTRL, 8'h03);
        op(CMD_ERASE, 8'h00, 8'h00, 16'h1000, 1);
        xw(XD_PCTRL, 8'h00);
        op(CMD_ERASE, 8'ha1, 8'h01, 16'h0000, 7);
        sw(SFR_MODE, 8'h09);
        src(SFR_MODE, 8'h09, "mode readback");
        chk({7'h00, o_fl_otp}, 8'h01, "otp access");
        sw(SFR_CMD, CMD_EXIT);
        sw(SFR_CMD, CMD_PROG);
        src(SFR_STAT, 8'h88, "start after exit");
        chk({7'h00, o_cpu_halt}, 8'h00, "no halt after exit");
        give_verdict();
    end
endmodule : tb_fpec_ctrl

//--- verilog/fpec_ctrl.sv
// flash program/erase sequencer with timer, checksum verify and write protection
// assumes single-cycle bus strobes and a flash array with one-cycle read latency
`timescale 1ns/1ps
// Function
// - 10-bit timer clocked by crystal divided 64
// - timer clears at start, stops at target
// - bulk target is time value then 11
// - page target is 0, time value, 1
// - verify steps address, sums 24-bit checksum
// - lock window refuses program and erase
// - unlock window overrides overlapping lock, except for bulk erase
// - updates start only by command writes
// - 03 starts erase, 05 starts program
// - 31 leaves program/erase mode
// - many operations allowed per mode session
// - cpu clock halted while operation runs
// - status shows program, erase, verify mode
// - read, program, page and bulk erase, verify
// - completion flag low while busy
// - interrupt flag set at end, cleared at start
// - address registers hold target page
module fpec_ctrl
    import fpec_pkg::*;
(
    input  logic                i_clk_sys,
    input  logic                i_srst,
    input  fpec_pkg::fpec_bus_s i_sfr,
    output logic [7:0]          o_sfr_rdata,
    input  fpec_pkg::fpec_bus_s i_xd,
    output logic [7:0]          o_xd_rdata,
    input  logic                i_crys_clk,
    input  logic [7:0]          i_fl_rdata,
    output logic [15:0]         o_fl_addr,
    output logic [7:0]          o_fl_wdata,
    output logic                o_fl_wr,
    output logic                o_fl_rd,
    output logic                o_fl_prog,
    output logic                o_fl_erase,
    output logic                o_fl_bulk,
    output logic                o_fl_otp,
    output logic                o_cpu_halt
);
    import fpec_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_LOAD  = 5'b00010,
        ST_TIME  = 5'b00100,
        ST_CHECK = 5'b01000,
        ST_DRAIN = 5'b10000
    } fpec_state_e;

    fpec_state_e       state_reg;
    logic [7:0]        mode_reg, addr_h_reg, addr_m_reg, addr_l_reg;
    logic [7:0]        cmd_reg, time_reg;
    logic [15:0]       lb_reg, lt_reg, ub_reg, ut_reg;
    logic [1:0]        prot_reg;
    logic [23:0]       sum_reg;
    logic              session_reg, done_reg, int_reg;
    logic [1:0]        seq_reg;
    logic [7:0]        pbuf_mem [64];
    logic [63:0]       pbuf_vld_reg;
    logic [TMR_W-1:0]  tmr_reg, tgt_reg;
    logic [PRE_W-1:0]  pre_reg;
    logic              crys_s1_reg, crys_s2_reg, crys_s3_reg, tick_reg;
    logic [15:0]       idx_reg;
    logic              op_erase_reg, op_bulk_reg, op_chk_reg, rd_pend_reg;

    logic        sfr_cmd_wr, start_cmd, erase_cmd, bulk_cmd, prot_hit, go;
    logic [15:0] pg_base, last_idx;
    logic        in_lock, in_unl;

    assign sfr_cmd_wr = i_sfr.wr && i_sfr.addr[7:0] == SFR_CMD;
    assign erase_cmd  = i_sfr.wdata == CMD_ERASE;
    // a start is only ever a command-register write inside a mode session
    assign start_cmd  = sfr_cmd_wr && session_reg && state_reg == ST_IDLE
                        && (erase_cmd || i_sfr.wdata == CMD_PROG);
    assign bulk_cmd   = erase_cmd && mode_reg[MODE_BULK] && mode_reg[MODE_SEL];
    assign pg_base    = {addr_m_reg, addr_l_reg} & PAGE_MASK;
    // both bounds inclusive
    assign in_lock    = prot_reg[PROT_LOCK] && pg_base >= lb_reg && pg_base <= lt_reg;
    assign in_unl     = prot_reg[PROT_UNL] && pg_base >= ub_reg && pg_base <= ut_reg;
    // bulk touches every page, so any active lock refuses it
    assign prot_hit   = bulk_cmd ? prot_reg[PROT_LOCK] : (in_lock && !in_unl);
    assign go         = start_cmd && !prot_hit;
    assign last_idx   = op_bulk_reg ? ARR_LAST : PAGE_LAST;

    // crystal pin crossing; s1 feeds only s2
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            crys_s1_reg <= 1'b0;
            crys_s2_reg <= 1'b0;
            crys_s3_reg <= 1'b0;
        end
        else
        begin
            crys_s1_reg <= i_crys_clk;
            crys_s2_reg <= crys_s1_reg;
            crys_s3_reg <= crys_s2_reg;
        end
    end

    // divide crystal rising edges by 64; held clear outside the timed phase so
    // every operation gets its full length, not a random first tick
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            pre_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= 1'b0;
            if (state_reg != ST_TIME)
                pre_reg <= '0;
            else if (crys_s2_reg && !crys_s3_reg)
            begin
                pre_reg  <= pre_reg + 1'b1;
                tick_reg <= &pre_reg;
            end
        end
    end

    // special-function registers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            mode_reg   <= REG_RST;
            addr_h_reg <= REG_RST;
            addr_m_reg <= REG_RST;
            addr_l_reg <= REG_RST;
            time_reg   <= REG_RST;
            cmd_reg    <= CMD_RST;
        end
        else
        begin
            // page buffer reset and exit bits self-restore one cycle later
            cmd_reg <= (cmd_reg | CMD_ASET) & ~CMD_ACLR;
            if (i_sfr.wr)
            begin
                case (i_sfr.addr[7:0])
                    SFR_MODE:   mode_reg   <= i_sfr.wdata;
                    SFR_ADDR_H: addr_h_reg <= i_sfr.wdata;
                    SFR_ADDR_M: addr_m_reg <= i_sfr.wdata;
                    SFR_ADDR_L: addr_l_reg <= i_sfr.wdata;
                    SFR_TIME:   time_reg   <= i_sfr.wdata;
                    SFR_CMD:    cmd_reg    <= i_sfr.wdata;
                    default:    ;
                endcase
            end
        end
    end

    // protection window registers, each boundary built from two bytes
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            lb_reg   <= '0;
            lt_reg   <= '0;
            ub_reg   <= '0;
            ut_reg   <= '0;
            prot_reg <= '0;
        end
        else if (i_xd.wr)
        begin
            case (i_xd.addr)
                XD_LB_H:  lb_reg[15:8] <= i_xd.wdata;
                XD_LB_L:  lb_reg[7:0]  <= i_xd.wdata;
                XD_LT_H:  lt_reg[15:8] <= i_xd.wdata;
                XD_LT_L:  lt_reg[7:0]  <= i_xd.wdata;
                XD_UB_H:  ub_reg[15:8] <= i_xd.wdata;
                XD_UB_L:  ub_reg[7:0]  <= i_xd.wdata;
                XD_UT_H:  ut_reg[15:8] <= i_xd.wdata;
                XD_UT_L:  ut_reg[7:0]  <= i_xd.wdata;
                XD_PCTRL: prot_reg     <= i_xd.wdata[1:0];
                default:  ;
            endcase
        end
    end

    // mode session: three-write entry, exit command
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            seq_reg     <= 2'd0;
            session_reg <= 1'b0;
        end
        else
        begin
            if (i_xd.wr)
            begin
                seq_reg <= 2'd0;
                if (seq_reg == 2'd0 && i_xd.addr == XD_SEQ_A && i_xd.wdata == SEQ_1)
                    seq_reg <= 2'd1;
                else if (seq_reg == 2'd1 && i_xd.addr == XD_SEQ_B && i_xd.wdata == SEQ_2)
                    seq_reg <= 2'd2;
                else if (seq_reg == 2'd2 && i_xd.addr == XD_SEQ_A && i_xd.wdata == SEQ_3)
                    session_reg <= 1'b1;
            end
            if (sfr_cmd_wr && i_sfr.wdata == CMD_EXIT)
                session_reg <= 1'b0;
        end
    end

    // page buffer; unloaded bytes are skipped when programming
    always_ff @(posedge i_clk_sys)
    begin
        if (i_xd.wr && (i_xd.addr & PAGE_MASK) == XD_PBUF)
            pbuf_mem[i_xd.addr[5:0]] <= i_xd.wdata;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
            pbuf_vld_reg <= '0;
        else if (sfr_cmd_wr && i_sfr.wdata == CMD_PBRST)
            pbuf_vld_reg <= '0;
        else if (i_xd.wr && (i_xd.addr & PAGE_MASK) == XD_PBUF)
            pbuf_vld_reg[i_xd.addr[5:0]] <= 1'b1;
    end

    // operation sequencer
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_reg    <= ST_IDLE;
            tmr_reg      <= '0;
            tgt_reg      <= '0;
            idx_reg      <= '0;
            op_erase_reg <= 1'b0;
            op_bulk_reg  <= 1'b0;
            op_chk_reg   <= 1'b0;
            done_reg     <= 1'b1;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (go)
                    begin
                        tmr_reg      <= '0;
                        idx_reg      <= '0;
                        op_erase_reg <= erase_cmd;
                        op_bulk_reg  <= bulk_cmd;
                        op_chk_reg   <= mode_reg[MODE_CHK];
                        done_reg     <= 1'b0;
                        if (bulk_cmd)
                            tgt_reg <= {time_reg, TGT_BULK_LO};
                        else
                            tgt_reg <= {TGT_PE_HI, time_reg, TGT_PE_LO};
                        state_reg <= erase_cmd ? ST_TIME : ST_LOAD;
                    end
                ST_LOAD:
                begin
                    idx_reg <= idx_reg + 16'd1;
                    if (idx_reg == PAGE_LAST)
                        state_reg <= ST_TIME;
                end
                ST_TIME:
                    if (tmr_reg == tgt_reg)
                    begin
                        // counter holds its final value
                        idx_reg <= '0;
                        if (op_chk_reg)
                            state_reg <= ST_CHECK;
                        else
                        begin
                            state_reg <= ST_IDLE;
                            done_reg  <= 1'b1;
                        end
                    end
                    else if (tick_reg)
                        tmr_reg <= tmr_reg + 1'b1;
                ST_CHECK:
                begin
                    idx_reg <= idx_reg + 16'd1;
                    if (idx_reg == last_idx)
                        state_reg <= ST_DRAIN;
                end
                ST_DRAIN:
                begin
                    state_reg <= ST_IDLE;
                    done_reg  <= 1'b1;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // interrupt flag: completion set wins over a software clear
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
            int_reg <= 1'b0;
        else if (go)
            int_reg <= 1'b0;
        else if ((state_reg == ST_TIME && tmr_reg == tgt_reg && !op_chk_reg)
                 || state_reg == ST_DRAIN)
            int_reg <= 1'b1;
        else if (i_sfr.wr && i_sfr.addr[7:0] == SFR_STAT && !i_sfr.wdata[STA_INT])
            int_reg <= 1'b0;
    end

    // checksum of verify reads; the array answers a cycle after the registered
    // read strobe, so each byte is added two cycles after that strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            sum_reg     <= '0;
            rd_pend_reg <= 1'b0;
        end
        else
        begin
            rd_pend_reg <= o_fl_rd;
            if (go)
                sum_reg <= '0;
            else if (rd_pend_reg)
                sum_reg <= sum_reg + {16'h0000, i_fl_rdata};
        end
    end

    // array drive
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_fl_addr  <= '0;
            o_fl_wdata <= '0;
            o_fl_wr    <= 1'b0;
            o_fl_rd    <= 1'b0;
            o_fl_prog  <= 1'b0;
            o_fl_erase <= 1'b0;
            o_fl_bulk  <= 1'b0;
            o_fl_otp   <= 1'b0;
            o_cpu_halt <= 1'b0;
        end
        else
        begin
            o_fl_addr  <= op_bulk_reg ? idx_reg : (pg_base | idx_reg);
            o_fl_wdata <= pbuf_mem[idx_reg[5:0]];
            o_fl_wr    <= state_reg == ST_LOAD && pbuf_vld_reg[idx_reg[5:0]];
            o_fl_rd    <= state_reg == ST_CHECK;
            o_fl_prog  <= state_reg == ST_TIME && !op_erase_reg;
            o_fl_erase <= state_reg == ST_TIME && op_erase_reg;
            o_fl_bulk  <= state_reg == ST_TIME && op_bulk_reg;
            o_fl_otp   <= mode_reg[MODE_OTP];
            o_cpu_halt <= state_reg != ST_IDLE;
        end
    end

    // register reads, answered the cycle after the strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            o_sfr_rdata <= '0;
            o_xd_rdata  <= '0;
        end
        else
        begin
            o_sfr_rdata <= '0;
            o_xd_rdata  <= '0;
            if (i_sfr.rd)
            begin
                case (i_sfr.addr[7:0])
                    SFR_MODE:   o_sfr_rdata <= mode_reg;
                    SFR_ADDR_H: o_sfr_rdata <= addr_h_reg;
                    SFR_ADDR_M: o_sfr_rdata <= addr_m_reg;
                    SFR_ADDR_L: o_sfr_rdata <= addr_l_reg;
                    SFR_CMD:    o_sfr_rdata <= cmd_reg;
                    SFR_TIME:   o_sfr_rdata <= time_reg;
                    SFR_STAT:
                    begin
                        o_sfr_rdata[STA_DONE] <= done_reg;
                        o_sfr_rdata[STA_INT]  <= int_reg;
                        o_sfr_rdata[STA_PM]   <= state_reg != ST_IDLE && !op_erase_reg;
                        o_sfr_rdata[STA_EM]   <= state_reg != ST_IDLE && op_erase_reg;
                        o_sfr_rdata[STA_VM]   <= state_reg == ST_CHECK || state_reg == ST_DRAIN;
                    end
                    default:    ;
                endcase
            end
            if (i_xd.rd)
            begin
                if ((i_xd.addr & PAGE_MASK) == XD_PBUF)
                    o_xd_rdata <= pbuf_mem[i_xd.addr[5:0]];
                else
                begin
                    case (i_xd.addr)
                        XD_SUM_H:  o_xd_rdata <= sum_reg[23:16];
                        XD_SUM_M:  o_xd_rdata <= sum_reg[15:8];
                        XD_SUM_L:  o_xd_rdata <= sum_reg[7:0];
                        XD_LB_H:   o_xd_rdata <= lb_reg[15:8];
                        XD_LB_L:   o_xd_rdata <= lb_reg[7:0];
                        XD_LT_H:   o_xd_rdata <= lt_reg[15:8];
                        XD_LT_L:   o_xd_rdata <= lt_reg[7:0];
                        XD_UB_H:   o_xd_rdata <= ub_reg[15:8];
                        XD_UB_L:   o_xd_rdata <= ub_reg[7:0];
                        XD_UT_H:   o_xd_rdata <= ut_reg[15:8];
                        XD_UT_L:   o_xd_rdata <= ut_reg[7:0];
                        XD_PCTRL:  o_xd_rdata <= {6'h00, prot_reg};
                        default:   ;
                    endcase
                end
            end
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    sequence s_start;
        go;
    endsequence
    sequence s_finish;
        state_reg != ST_IDLE ##1 state_reg == ST_IDLE;
    endsequence

    property p_tmr_tick;
        (state_reg == ST_TIME && !tick_reg && tmr_reg != tgt_reg) |=> $stable(tmr_reg);
    endproperty
    a_tmr_tick: assert property (p_tmr_tick) else $error("timer moved without tick");
    property p_start_clear;
        s_start |=> tmr_reg == '0 && !done_reg && !int_reg;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start did not clear");
    property p_tgt_bulk;
        (go && bulk_cmd) |=> tgt_reg == {$past(time_reg), 2'b11};
    endproperty
    a_tgt_bulk: assert property (p_tgt_bulk) else $error("bad bulk target");
    property p_tgt_page;
        (go && !bulk_cmd) |=> tgt_reg == {1'b0, $past(time_reg), 1'b1};
    endproperty
    a_tgt_page: assert property (p_tgt_page) else $error("bad page target");
    property p_vfy_step;
        (state_reg == ST_CHECK && idx_reg != last_idx) |=> idx_reg == $past(idx_reg) + 16'd1;
    endproperty
    a_vfy_step: assert property (p_vfy_step) else $error("verify address skipped");
    property p_refuse;
        (start_cmd && prot_hit) |=> state_reg == ST_IDLE && done_reg;
    endproperty
    a_refuse: assert property (p_refuse) else $error("protected start ran");
    property p_only_cmd;
        (state_reg == ST_IDLE && !go) |=> state_reg == ST_IDLE;
    endproperty
    a_only_cmd: assert property (p_only_cmd) else $error("update began without command");
    property p_exit;
        (sfr_cmd_wr && i_sfr.wdata == CMD_EXIT) |=> !session_reg;
    endproperty
    a_exit: assert property (p_exit) else $error("exit ignored");
    property p_halt;
        state_reg != ST_IDLE |=> o_cpu_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("cpu not halted");
    property p_done;
        done_reg == (state_reg == ST_IDLE);
    endproperty
    a_done: assert property (p_done) else $error("completion flag wrong");
    property p_end_int;
        s_finish |-> int_reg && session_reg;
    endproperty
    a_end_int: assert property (p_end_int) else $error("end flag or session lost");
endmodule : fpec_ctrl

//--- verilog/fpec_pkg.sv
// constants, field positions and bus carrier for the flash program/erase controller
// assumes an 8-bit cpu with special-function and extended-data write/read strobes
package fpec_pkg;
    // special-function register offsets
    localparam logic [7:0]  SFR_MODE   = 8'he1;
    localparam logic [7:0]  SFR_ADDR_H = 8'he9;
    localparam logic [7:0]  SFR_ADDR_M = 8'hea;
    localparam logic [7:0]  SFR_ADDR_L = 8'heb;
    localparam logic [7:0]  SFR_CMD    = 8'hec;
    localparam logic [7:0]  SFR_STAT   = 8'hed;
    localparam logic [7:0]  SFR_TIME   = 8'hee;
    // extended-data offsets
    localparam logic [15:0] XD_SUM_H   = 16'h2f06;
    localparam logic [15:0] XD_SUM_M   = 16'h2f07;
    localparam logic [15:0] XD_SUM_L   = 16'h2f0f;
    localparam logic [15:0] XD_LB_H    = 16'h2f61;
    localparam logic [15:0] XD_LB_L    = 16'h2f62;
    localparam logic [15:0] XD_LT_H    = 16'h2f64;
    localparam logic [15:0] XD_LT_L    = 16'h2f65;
    localparam logic [15:0] XD_UB_H    = 16'h2f67;
    localparam logic [15:0] XD_UB_L    = 16'h2f68;
    localparam logic [15:0] XD_UT_H    = 16'h2f6a;
    localparam logic [15:0] XD_UT_L    = 16'h2f6b;
    localparam logic [15:0] XD_PCTRL   = 16'h2f6c;
    localparam logic [15:0] XD_PBUF    = 16'h8000;
    localparam logic [15:0] PAGE_MASK  = 16'hffc0;
    localparam logic [15:0] XD_SEQ_A   = 16'hf555;
    localparam logic [15:0] XD_SEQ_B   = 16'hfaaa;
    localparam logic [7:0]  SEQ_1      = 8'haa;
    localparam logic [7:0]  SEQ_2      = 8'h55;
    localparam logic [7:0]  SEQ_3      = 8'ha5;
    // command codes and auto-set/clear bits of the command register
    localparam logic [7:0]  CMD_PBRST  = 8'h00;
    localparam logic [7:0]  CMD_ERASE  = 8'h03;
    localparam logic [7:0]  CMD_PROG   = 8'h05;
    localparam logic [7:0]  CMD_EXIT   = 8'h31;
    localparam logic [7:0]  CMD_ASET   = 8'h01;
    localparam logic [7:0]  CMD_ACLR   = 8'h30;
    // reset values
    localparam logic [7:0]  CMD_RST    = 8'h01;
    localparam logic [7:0]  REG_RST    = 8'h00;
    // field positions
    localparam int          MODE_BULK  = 7;
    localparam int          MODE_SEL   = 5;
    localparam int          MODE_OTP   = 3;
    localparam int          MODE_CHK   = 1;
    localparam int          STA_DONE   = 7;
    localparam int          STA_INT    = 3;
    localparam int          STA_PM     = 2;
    localparam int          STA_EM     = 1;
    localparam int          STA_VM     = 0;
    localparam int          PROT_LOCK  = 0;
    localparam int          PROT_UNL   = 1;
    // timing: 10-bit counter, crystal divided by 64
    localparam int          TMR_W      = 10;
    localparam int          CRYS_DIV   = 64;
    localparam int          PRE_W      = $clog2(CRYS_DIV);
    localparam logic [1:0]  TGT_BULK_LO = 2'b11;
    localparam logic        TGT_PE_HI  = 1'b0;
    localparam logic        TGT_PE_LO  = 1'b1;
    localparam logic [15:0] PAGE_LAST  = 16'h003f;
    localparam logic [15:0] ARR_LAST   = 16'hffff;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } fpec_bus_s;
endpackage : fpec_pkg
